/* verilog/pcc_pkg.sv */
// Package for the synthesizer configuration and clock flag block.
// Assumes an AXI4-Lite master with 32-bit data and one outstanding
// access per direction.
package pcc_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register indices; the byte address is four times the index
   localparam logic [3:0] IDX_MULT = 4'h4;
   localparam logic [3:0] IDX_REF_DIV = 4'h5;
   localparam logic [3:0] IDX_POST_DIV = 4'h6;
   localparam logic [3:0] IDX_FLAGS = 4'h7;
   localparam logic [3:0] IDX_ENABLE = 4'h8;
   localparam logic [3:0] IDX_CTRL = 4'hA;

   // Multiplier register fields
   localparam int MULT_LSB = 0;
   localparam int VCO_RANGE_LSB = 6;
   // Reference divider register fields
   localparam int REF_DIV_LSB = 0;
   localparam int REF_RANGE_LSB = 6;
   // Control register fields
   localparam int CTRL_GUARD_BIT = 0;
   localparam int CTRL_XTAL_BIT = 6;
   localparam int CTRL_SEL_BIT = 7;
   // Flag and enable register bit positions
   localparam int OSC_QUAL_BIT = 0;
   localparam int OSC_FLAG_BIT = 1;
   localparam int SETTLE_BIT = 3;
   localparam int SETTLE_FLAG_BIT = 4;
   localparam int TICK_FLAG_BIT = 7;
   localparam int NUM_FLAGS = 3;

   // Reset values
   localparam logic [7:0] MULT_RST = 8'h00;
   localparam logic [7:0] REF_DIV_RST = 8'h00;
   localparam logic [4:0] POST_DIV_RST = 5'h00;
   localparam logic [2:0] ENABLE_RST = 3'h0;
   localparam logic SEL_RST = 1'b1;
   localparam logic XTAL_RST = 1'b0;
   localparam logic GUARD_RST = 1'b0;

   // Fixed filter range for the internal RC reference
   localparam logic [1:0] RC_FILTER_RANGE = 2'h0;
   // Output divider field that gives one quarter of the VCO
   localparam logic [4:0] DIV_QUARTER = 5'h03;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Status from the analog synthesizer and oscillator
   typedef struct packed {
      logic settled;
      logic osc_good;
      logic tick;
      logic full_stop;
   } pcc_status_t;

   // Configuration to the analog synthesizer
   typedef struct packed {
      logic [5:0] multiplier_field;
      logic [1:0] vco_range_field;
      logic [7:0] vco_ratio;
      logic [3:0] ref_divider_field;
      logic [1:0] filter_range;
      logic crystal_ref;
      logic [4:0] out_divider;
      logic synth_clock_select;
      logic relock;
   } pcc_synth_cfg_t;

endpackage

/* verilog/pcc_flag_cell.sv */
// Sticky event flag, cleared by software writing a one.
// Assumes set and clear are single-cycle qualified strobes.
`timescale 1ns/1ps
`default_nettype none
module pcc_flag_cell
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Event and clear
   input wire logic set,
   input wire logic clr,
   output logic flag_q
);
   import pcc_pkg::*;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flag_q <= 1'b0;
      else if (set)
         flag_q <= 1'b1;
      else if (clr)
         flag_q <= 1'b0;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_clear_one_only: assert property (
      (!set && !clr && flag_q) |=> flag_q)
      else $error("flag dropped without a clear");

   a_clear_takes: assert property (
      (!set && clr) |=> !flag_q)
      else $error("flag not cleared by a written one");

endmodule
`default_nettype wire

/* verilog/pcc_div_stepper.sv */
// Output divider that walks one step per bus clock toward its target.
// Assumes the bus clock is the clock of this module.
`timescale 1ns/1ps
`default_nettype none
module pcc_div_stepper
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Target and state
   input wire logic [4:0] target,
   input wire logic settled,
   output logic [4:0] div_q
);
   import pcc_pkg::*;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_q <= DIV_QUARTER;
      else if (!settled)
         div_q <= DIV_QUARTER;
      else if (div_q < target)
         div_q <= div_q + 5'h01;
      else if (div_q > target)
         div_q <= div_q - 5'h01;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_unsettled_quarter: assert property (
      !settled |=> div_q == DIV_QUARTER)
      else $error("divider not at quarter while unsettled");

   a_single_step: assert property (
      (settled && div_q != target) |=>
         (div_q == $past(div_q) + 5'h01 || div_q == $past(div_q) - 5'h01))
      else $error("divider did not move by exactly one step");

endmodule
`default_nettype wire

/* verilog/pcc_top.sv */
// Synthesizer configuration, status and clock event flags behind AXI4-Lite.
// Assumes analog status inputs already synchronous to aclk, the bus clock.
//
// Operation
// - Multiplier and divider writes need guard clear and synth clock.
// - Accepted multiplier or divider write clears settle and oscillator.
// - Settled VCO runs at twice reference times multiplier plus one.
// - Crystal enabled: reference is crystal over divider plus one.
// - RC reference forces the lowest filter range; field stays writable.
// - Post divider writes need the synthesizer clock selected.
// - Output is VCO over divider plus one, quarter while unsettled.
// - Bus clock is half the synthesizer output when selected.
// - Output divider steps gradually, at most 32 bus clocks.
// - Tick flag at bit 7 sets at each tick period end.
// - Settle change flag at bit 4 sets on any settle change.
// - Bit 3 reads the settle condition; writes ignored.
// - Oscillator change flag at bit 1 sets on qualified change.
// - Bit 0 reads oscillator qualified; cleared entering full stop.
// - Flags clear only by writing one; zero leaves them.
// - Enable register at bits 7, 4, 1 gates interrupt requests.
// - Select bit picks synthesizer or crystal for core and bus.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module pcc_top
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [pcc_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [pcc_pkg::DATA_W-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // AXI4-Lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [pcc_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [pcc_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Analog side
   input wire pcc_pkg::pcc_status_t status,
   output pcc_pkg::pcc_synth_cfg_t cfg_q,
   // Interrupt requests: osc change, settle change, tick
   output logic [pcc_pkg::NUM_FLAGS-1:0] irq_q
);
   import pcc_pkg::*;

   // Index of a mapped word, or all ones when unmapped
   function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] a);
      logic [3:0] idx;
      idx = a[5:2];
      if (a[ADDR_W-1:6] != '0)
         reg_index = 4'hF;
      else if (idx == IDX_MULT || idx == IDX_REF_DIV || idx == IDX_POST_DIV
               || idx == IDX_FLAGS || idx == IDX_ENABLE || idx == IDX_CTRL)
         reg_index = idx;
      else
         reg_index = 4'hF;
   endfunction

   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [DATA_W-1:0] wdata_q;
   logic lane0_q;
   logic wr_fire;
   logic [3:0] wr_idx;
   logic [3:0] rd_idx;
   logic [7:0] mult_q;
   logic [7:0] ref_div_q;
   logic [4:0] post_div_q;
   logic [2:0] enable_q;
   logic guard_q;
   logic xtal_q;
   logic sel_q;
   logic settle_q;
   logic osc_q;
   logic settle_d;
   logic osc_d;
   logic cfg_ok;
   logic cfg_wr;
   logic post_wr;
   logic flag_wr;
   logic [NUM_FLAGS-1:0] flag_set;
   logic [NUM_FLAGS-1:0] flag_clr;
   logic [NUM_FLAGS-1:0] flags_q;
   logic [4:0] div_now;
   logic [7:0] rd_byte;

   assign wr_fire = aw_held_q && w_held_q && !bvalid;
   assign wr_idx = reg_index(awaddr_q);
   assign rd_idx = reg_index(araddr);
   assign cfg_ok = !guard_q && sel_q;
   assign cfg_wr = wr_fire && lane0_q && cfg_ok
                   && (wr_idx == IDX_MULT || wr_idx == IDX_REF_DIV);
   assign post_wr = wr_fire && lane0_q && sel_q && wr_idx == IDX_POST_DIV;
   assign flag_wr = wr_fire && lane0_q && wr_idx == IDX_FLAGS;

   // Write address and data channels, taken in either order
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         awready <= 1'b1;
         awaddr_q <= '0;
      end
      else if (awvalid && awready)
      begin
         aw_held_q <= 1'b1;
         awready <= 1'b0;
         awaddr_q <= awaddr;
      end
      else if (wr_fire)
         aw_held_q <= 1'b0;
      else if (bvalid && bready)
         awready <= 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_q <= 1'b0;
         wready <= 1'b1;
         wdata_q <= '0;
         lane0_q <= 1'b0;
      end
      else if (wvalid && wready)
      begin
         w_held_q <= 1'b1;
         wready <= 1'b0;
         wdata_q <= wdata;
         lane0_q <= wstrb[0];
      end
      else if (wr_fire)
         w_held_q <= 1'b0;
      else if (bvalid && bready)
         wready <= 1'b1;
   end

   // Write response; refused writes still answer OKAY
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid <= 1'b1;
         bresp <= (wr_idx == 4'hF) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (bvalid && bready)
         bvalid <= 1'b0;
   end

   // Configuration registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mult_q <= MULT_RST;
         ref_div_q <= REF_DIV_RST;
      end
      else if (cfg_wr && wr_idx == IDX_MULT)
         mult_q <= wdata_q[7:0];
      else if (cfg_wr)
         ref_div_q <= wdata_q[7:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         post_div_q <= POST_DIV_RST;
      else if (post_wr)
         post_div_q <= wdata_q[4:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         enable_q <= ENABLE_RST;
      else if (wr_fire && lane0_q && wr_idx == IDX_ENABLE)
         enable_q <= {wdata_q[TICK_FLAG_BIT], wdata_q[SETTLE_FLAG_BIT],
                      wdata_q[OSC_FLAG_BIT]};
   end

   // clock source select
   // Crystal may only be chosen once it is qualified
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sel_q <= SEL_RST;
         xtal_q <= XTAL_RST;
         guard_q <= GUARD_RST;
      end
      else
      begin
         if (wr_fire && lane0_q && wr_idx == IDX_CTRL)
         begin
            guard_q <= wdata_q[CTRL_GUARD_BIT];
            xtal_q <= wdata_q[CTRL_XTAL_BIT];
            if (!guard_q)
               sel_q <= wdata_q[CTRL_SEL_BIT] || !osc_q;
         end
         if (!osc_q || status.full_stop)
            sel_q <= 1'b1;
      end
   end

   assign settle_d = status.settled && !cfg_wr;
   assign osc_d = status.osc_good && !cfg_wr && !status.full_stop;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         settle_q <= 1'b0;
         osc_q <= 1'b0;
      end
      else
      begin
         settle_q <= settle_d;
         osc_q <= osc_d;
      end
   end

   assign flag_set = {status.tick, settle_d != settle_q, osc_d != osc_q};
   assign flag_clr = {NUM_FLAGS{flag_wr}} &
                     {wdata_q[TICK_FLAG_BIT], wdata_q[SETTLE_FLAG_BIT],
                      wdata_q[OSC_FLAG_BIT]};

   genvar gi;
   generate
      for (gi = 0; gi < NUM_FLAGS; gi = gi + 1)
      begin : g_flag
         pcc_flag_cell u_flag
         (
            .aclk(aclk),
            .aresetn(aresetn),
            .set(flag_set[gi]),
            .clr(flag_clr[gi]),
            .flag_q(flags_q[gi])
         );
      end
   endgenerate

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_q <= '0;
      else
         irq_q <= flags_q & enable_q;
   end

   pcc_div_stepper u_step
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .target(post_div_q),
      .settled(settle_q),
      .div_q(div_now)
   );

   // VCO ratio two times field plus one
   // bus clock is half, divided downstream
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_q <= '0;
      else
      begin
         cfg_q.multiplier_field <= mult_q[MULT_LSB +: 6];
         cfg_q.vco_range_field <= mult_q[VCO_RANGE_LSB +: 2];
         cfg_q.vco_ratio <= {1'b0, mult_q[MULT_LSB +: 6], 1'b0} + 8'h02;
         cfg_q.ref_divider_field <= ref_div_q[REF_DIV_LSB +: 4];
         cfg_q.filter_range <= xtal_q ? ref_div_q[REF_RANGE_LSB +: 2]
                                      : RC_FILTER_RANGE;
         cfg_q.crystal_ref <= xtal_q;
         cfg_q.out_divider <= div_now;
         cfg_q.synth_clock_select <= sel_q;
         cfg_q.relock <= cfg_wr;
      end
   end

   // Read data byte for a mapped index
   always_comb
   begin
      rd_byte = 8'h00;
      case (rd_idx)
         IDX_MULT: rd_byte = mult_q;
         IDX_REF_DIV: rd_byte = ref_div_q;
         IDX_POST_DIV: rd_byte = {3'h0, post_div_q};
         IDX_FLAGS:
         begin
            rd_byte[TICK_FLAG_BIT] = flags_q[2];
            rd_byte[SETTLE_FLAG_BIT] = flags_q[1];
            rd_byte[SETTLE_BIT] = settle_q;
            rd_byte[OSC_FLAG_BIT] = flags_q[0];
            rd_byte[OSC_QUAL_BIT] = osc_q;
         end
         IDX_ENABLE:
         begin
            rd_byte[TICK_FLAG_BIT] = enable_q[2];
            rd_byte[SETTLE_FLAG_BIT] = enable_q[1];
            rd_byte[OSC_FLAG_BIT] = enable_q[0];
         end
         IDX_CTRL:
         begin
            rd_byte[CTRL_SEL_BIT] = sel_q;
            rd_byte[CTRL_XTAL_BIT] = xtal_q;
            rd_byte[CTRL_GUARD_BIT] = guard_q;
         end
         default: rd_byte = 8'h00;
      endcase
   end

   // Read channel, answered one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= {24'h00_0000, rd_byte};
         rresp <= (rd_idx == 4'hF) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_guard_blocks_cfg: assert property (
      (wr_fire && !cfg_ok && wr_idx == IDX_MULT) |=> $stable(mult_q))
      else $error("multiplier written while guarded");

   a_cfg_clears_status: assert property (
      cfg_wr |=> (!settle_q && !osc_q))
      else $error("status kept after reconfiguration");

   a_post_guard: assert property (
      (wr_fire && !sel_q && wr_idx == IDX_POST_DIV) |=> $stable(post_div_q))
      else $error("post divider written without synth clock");

   a_rc_filter_fixed: assert property (
      !xtal_q |=> cfg_q.filter_range == RC_FILTER_RANGE)
      else $error("filter range not fixed for RC reference");

   a_settle_change_flag: assert property (
      $changed(settle_q) |-> flags_q[1])
      else $error("settle change did not set its flag");

   a_osc_change_flag: assert property (
      $changed(osc_q) |-> flags_q[0])
      else $error("oscillator change did not set its flag");

   a_irq_drop: assert property (
      (!flags_q[2] || !enable_q[2]) |=> !irq_q[2])
      else $error("tick request without flag and enable");

   a_irq_hold: assert property (
      (flags_q[1] && enable_q[1]) ##1 (flags_q[1] && enable_q[1])
         |-> irq_q[1])
      else $error("settle request missing while enabled");

   a_full_stop_osc: assert property (
      status.full_stop |=> !osc_q)
      else $error("qualification kept in full stop");

   a_read_answer: assert property (
      (arvalid && arready) |=> (rvalid && !arready))
      else $error("read not answered next cycle");

endmodule
`default_nettype wire

/* testbench/pcc_top_tb_top.sv */
// Self-checking bench for the synthesizer configuration and flag block.
// Assumes pcc_pkg and the design compiled first; the bench drives status.
`timescale 1ns/1ps
`default_nettype none
module pcc_top_tb_top;
   import pcc_pkg::*;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   pcc_status_t status;
   pcc_synth_cfg_t cfg_q;
   logic [NUM_FLAGS-1:0] irq_q;
   int fails = 0;
   int tests_run = 0;
   int relock_cnt = 0;

   pcc_top pcc_top_i
   (
      .aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .status(status), .cfg_q(cfg_q), .irq_q(irq_q)
   );

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // Relock strobes counted so refused writes show no side effect
   always @(posedge aclk)
      if (cfg_q.relock === 1'b1)
         relock_cnt++;

   function automatic logic [7:0] ra(input logic [3:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_up();
      fails++;
      $display("[FAIL] handshake expected answer seen timeout");
      summarize();
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s, output logic [1:0] r);
      int n;
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      n = 0;
      awaddr <= a;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         n++;
         if (n > 50)
            give_up();
         if (aw_ok && w_ok && bvalid === 1'b1)
            break;
         aw_ok = aw_ok || awready === 1'b1;
         w_ok = w_ok || wready === 1'b1;
         if (aw_ok)
            awvalid <= 1'b0;
         if (w_ok)
            wvalid <= 1'b0;
      end
      r = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      logic ar_ok;
      ar_ok = 1'b0;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge aclk);
         n++;
         if (n > 50)
            give_up();
         if (ar_ok && rvalid === 1'b1)
            break;
         ar_ok = ar_ok || arready === 1'b1;
         if (ar_ok)
            arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic wchk(input logic [3:0] idx, input logic [7:0] v);
      logic [1:0] r;
      wr(ra(idx), v, 4'hF, r);
      check("write resp", 8'(r), 8'(RESP_OKAY));
   endtask

   task automatic rchk(input string what, input logic [3:0] idx,
      input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(ra(idx), d, r);
      check(what, d[7:0], exp);
      check("read resp", 8'(r), 8'(RESP_OKAY));
      check("rdata upper", 8'(d[31:8] !== 24'h00_0000), 8'h00);
   endtask

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] r;
      rchk("mult reset", IDX_MULT, 8'h00);
      rchk("ref div reset", IDX_REF_DIV, 8'h00);
      rchk("post div reset", IDX_POST_DIV, 8'h00);
      rchk("enable reset", IDX_ENABLE, 8'h00);
      rchk("ctrl reset", IDX_CTRL, 8'h80);
      check("irq reset", 8'(irq_q), 8'h00);
      check("div reset", 8'(cfg_q.out_divider), 8'(DIV_QUARTER));
      rd(8'h00, d, r);
      check("unmapped rresp", 8'(r), 8'(RESP_SLVERR));
      check("unmapped data", d[7:0], 8'h00);
      wr(8'h00, 8'h55, 4'hF, r);
      check("unmapped bresp", 8'(r), 8'(RESP_SLVERR));
      $display("test reset done");
   endtask

   task automatic t_guard();
      int n;
      logic [1:0] r;
      status.osc_good <= 1'b1;
      idle(3);
      n = relock_cnt;
      // VCO band 01
      // RC reference of 1 MHz times 52 keeps the VCO at 52 MHz
      wchk(IDX_MULT, 8'h59);
      rchk("mult open", IDX_MULT, 8'h59);
      check("vco ratio", cfg_q.vco_ratio, 8'h34);
      check("mult field", 8'(cfg_q.multiplier_field), 8'h19);
      check("vco range", 8'(cfg_q.vco_range_field), 8'h01);
      wchk(IDX_CTRL, 8'h81);
      wchk(IDX_MULT, 8'h17);
      rchk("mult guarded", IDX_MULT, 8'h59);
      wchk(IDX_CTRL, 8'h80);
      wchk(IDX_CTRL, 8'h00);
      rchk("ctrl crystal", IDX_CTRL, 8'h00);
      check("cfg select", 8'(cfg_q.synth_clock_select), 8'h00);
      wchk(IDX_MULT, 8'h17);
      wchk(IDX_POST_DIV, 8'h05);
      rchk("mult unselected", IDX_MULT, 8'h59);
      rchk("post div unselected", IDX_POST_DIV, 8'h00);
      check("relock count", 8'(relock_cnt - n), 8'h01);
      wr(ra(IDX_CTRL), 8'h80, 4'h0, r);
      rchk("no strobe", IDX_CTRL, 8'h00);
      wchk(IDX_CTRL, 8'h80);
      wchk(IDX_POST_DIV, 8'h05);
      rchk("post div selected", IDX_POST_DIV, 8'h05);
      $display("test guard done");
   endtask

   task automatic t_flags();
      status.settled <= 1'b1;
      idle(3);
      rchk("settle rise", IDX_FLAGS, 8'h1B);
      wchk(IDX_FLAGS, 8'h92);
      rchk("flags cleared", IDX_FLAGS, 8'h09);
      wchk(IDX_MULT, 8'h59);
      idle(3);
      wchk(IDX_FLAGS, 8'h09);
      rchk("drops status", IDX_FLAGS, 8'h1B);
      wchk(IDX_FLAGS, 8'h12);
      rchk("one clears", IDX_FLAGS, 8'h09);
      status.full_stop <= 1'b1;
      idle(3);
      rchk("full stop", IDX_FLAGS, 8'h0A);
      rchk("full stop select", IDX_CTRL, 8'h80);
      status.full_stop <= 1'b0;
      idle(3);
      $display("test flags done");
   endtask

   task automatic t_irq();
      wchk(IDX_FLAGS, 8'h92);
      wchk(IDX_ENABLE, 8'h92);
      rchk("enable rw", IDX_ENABLE, 8'h92);
      check("irq idle", 8'(irq_q), 8'h00);
      status.tick <= 1'b1;
      @(posedge aclk);
      status.tick <= 1'b0;
      idle(3);
      check("tick irq", 8'(irq_q), 8'h04);
      wchk(IDX_FLAGS, 8'h00);
      check("irq held", 8'(irq_q), 8'h04);
      wchk(IDX_FLAGS, 8'h80);
      idle(2);
      check("irq drop", 8'(irq_q), 8'h00);
      status.settled <= 1'b0;
      idle(3);
      check("settle irq", 8'(irq_q), 8'h02);
      wchk(IDX_ENABLE, 8'h02);
      idle(2);
      check("masked", 8'(irq_q), 8'h00);
      rchk("flag kept", IDX_FLAGS, 8'h11);
      status.osc_good <= 1'b0;
      idle(3);
      check("osc irq", 8'(irq_q), 8'h01);
      status.osc_good <= 1'b1;
      wchk(IDX_FLAGS, 8'h12);
      idle(2);
      check("irq cleared", 8'(irq_q), 8'h00);
      $display("test irq done");
   endtask

   // Loop bound above 32 leaves room for status and output register delay
   task automatic step_to(input logic [4:0] tgt);
      int n;
      int jumps;
      logic [4:0] prev;
      n = 0;
      jumps = 0;
      prev = cfg_q.out_divider;
      while (cfg_q.out_divider !== tgt && n < 40)
      begin
         @(posedge aclk);
         n++;
         if (cfg_q.out_divider !== prev && cfg_q.out_divider !== prev + 5'h01
            && cfg_q.out_divider !== prev - 5'h01)
            jumps++;
         prev = cfg_q.out_divider;
      end
      check("div target", 8'(cfg_q.out_divider), 8'(tgt));
      check("single steps", 8'(jumps), 8'h00);
      check("step time", 8'(n <= 32), 8'h01);
   endtask

   task automatic t_div();
      // reference band 01
      // A 12 MHz crystal over 3 gives a 4 MHz reference
      wchk(IDX_REF_DIV, 8'h42);
      check("ref div", 8'(cfg_q.ref_divider_field), 8'h02);
      check("rc band", 8'(cfg_q.filter_range), 8'(RC_FILTER_RANGE));
      rchk("ref range kept", IDX_REF_DIV, 8'h42);
      wchk(IDX_CTRL, 8'hC0);
      check("xtal ref", 8'(cfg_q.crystal_ref), 8'h01);
      check("xtal filter", 8'(cfg_q.filter_range), 8'h01);
      // VCO band 01
      // Reference of 4 MHz times 14 keeps the VCO at 56 MHz
      wchk(IDX_MULT, 8'h46);
      wchk(IDX_POST_DIV, 8'h10);
      check("quarter", 8'(cfg_q.out_divider), 8'(DIV_QUARTER));
      status.settled <= 1'b1;
      step_to(5'h10);
      wchk(IDX_POST_DIV, 8'h01);
      step_to(5'h01);
      status.settled <= 1'b0;
      // Status, divider and output register each add one clock
      idle(4);
      check("unsettle div", 8'(cfg_q.out_divider), 8'(DIV_QUARTER));
      $display("test divider done");
   endtask

   initial
   begin
      aresetn = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      status = '0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_guard();
      t_flags();
      t_irq();
      t_div();
      summarize();
   end
endmodule
`default_nettype wire
